// [clock_output_and_status_regs.sv]
// Output control and status register bank of the dual-PLL clock synthesizer
`timescale 1ns/1ps
module clock_output_and_status_regs (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire clkreg_pkg::reg_req_s reg_req,
   input wire clkreg_pkg::status_in_s status_in,
   output logic [clkreg_pkg::DATA_W-1:0] reg_rdata_r,
   output logic reg_rvalid_r,
   output clkreg_pkg::int_out_s [clkreg_pkg::NUM_INT_OUT-1:0] integer_clock_output_r,
   output clkreg_pkg::frac_out_s fractional_clock_output_r,
   output clkreg_pkg::aux_out_s aux_clock_output_r,
   output logic irq_out_n_r
);
   import clkreg_pkg::*;

   // Reset synchroniser stages
   logic rst_meta_r;
   logic rst_n;
   // Interrupt enables, low six bits used
   logic [NUM_EVENTS-1:0] irq_enable_r;
   // Sticky event flags and their gated requests
   logic [NUM_EVENTS-1:0] event_seen;
   logic [NUM_EVENTS-1:0] irq_request;
   // Address decode results
   logic [NUM_INT_OUT-1:0] hit_int;
   logic [DATA_W-1:0] int_rd [NUM_INT_OUT];
   logic [DATA_W-1:0] int_rd_any;
   logic [DATA_W-1:0] rdata_nxt;

   // Release reset through two flip-flops
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   // Single-register decodes
   wire hit_frac = (reg_req.addr == ADDR_FRAC_OUT);
   wire hit_aux = (reg_req.addr == ADDR_AUX_OUT);
   wire hit_ien = (reg_req.addr == ADDR_IRQ_ENABLE);
   wire hit_latched = (reg_req.addr == ADDR_LATCHED);
   wire hit_moment = (reg_req.addr == ADDR_MOMENTARY);
   wire hit_osc = (reg_req.addr == ADDR_OSC_SELECT);
   // Write strobes
   wire we_frac = reg_req.write & hit_frac;
   wire we_aux = reg_req.write & hit_aux;
   wire we_ien = reg_req.write & hit_ien;
   wire we_latched = reg_req.write & hit_latched;
   // Latched register clears on ones written, reserved bits ignored
   wire [NUM_EVENTS-1:0] clear_mask = we_latched ? reg_req.wdata[NUM_EVENTS-1:0] : '0;
   // Aux format field of a write, and its LVCMOS decode
   wire [1:0] aux_style_w = reg_req.wdata[AUX_STYLE_HI:AUX_STYLE_LO];
   wire aux_cmos_w = aux_style_w[1];

   // Per-output decode, write and readback
   genvar gi;
   generate
      for (gi = 0; gi < NUM_INT_OUT; gi++) begin : g_int
         assign hit_int[gi] = (reg_req.addr == ADDR_INT_OUT[gi]);
         // Readback image with reserved bits at zero
         assign int_rd[gi] = hit_int[gi] ?
            {integer_clock_output_r[gi].powerdown, 2'h0, integer_clock_output_r[gi].lvpecl,
             integer_clock_output_r[gi].amplitude, 2'h0} : ZERO_BYTE;
         // Power, format and swing of one integer output
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               integer_clock_output_r[gi].powerdown <= PD_POWERED;
               integer_clock_output_r[gi].lvpecl <= STYLE_LVDS;
               integer_clock_output_r[gi].amplitude <= AMP_500MV;
            end else if (reg_req.write && hit_int[gi]) begin
               integer_clock_output_r[gi].powerdown <= reg_req.wdata[BIT_POWER];
               integer_clock_output_r[gi].lvpecl <= reg_req.wdata[BIT_STYLE];
               integer_clock_output_r[gi].amplitude <= reg_req.wdata[AMP_HI:AMP_LO];
            end
         end
      end
      // Event latches, one per status event
      for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_ev
         status_latch_cell u_cell (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .healthy_now(status_in.event_now[gi]),
            .clear(clear_mask[gi]),
            .irq_enable(irq_enable_r[gi]),
            .event_seen_r(event_seen[gi]),
            .irq_request(irq_request[gi])
         );
      end
   endgenerate

   // Merge the integer readbacks, only one can be selected
   always_comb begin
      int_rd_any = ZERO_BYTE;
      for (int i = 0; i < NUM_INT_OUT; i++) begin
         int_rd_any = int_rd_any | int_rd[i];
      end
   end

   // Fractional output: power bit is active low and gates the whole channel
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fractional_clock_output_r.power_on <= FRAC_POWER_OFF;
         fractional_clock_output_r.channel_powerdown <= ~FRAC_POWER_OFF;
         fractional_clock_output_r.lvpecl <= STYLE_LVDS;
         fractional_clock_output_r.amplitude <= AMP_500MV;
      end else if (we_frac) begin
         fractional_clock_output_r.power_on <= reg_req.wdata[BIT_POWER];
         fractional_clock_output_r.channel_powerdown <= ~reg_req.wdata[BIT_POWER];
         fractional_clock_output_r.lvpecl <= reg_req.wdata[BIT_STYLE];
         fractional_clock_output_r.amplitude <= reg_req.wdata[AMP_HI:AMP_LO];
      end
   end

   // Auxiliary output: two-bit format, LVCMOS pair runs in antiphase
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         aux_clock_output_r.powerdown <= PD_POWERED;
         aux_clock_output_r.style <= AUX_STYLE_LVCMOS;
         aux_clock_output_r.amplitude <= AMP_350MV;
         aux_clock_output_r.cmos_antiphase <= 1'b1;
      end else if (we_aux) begin
         aux_clock_output_r.powerdown <= reg_req.wdata[BIT_POWER];
         aux_clock_output_r.style <= aux_style_w;
         aux_clock_output_r.amplitude <= reg_req.wdata[AMP_HI:AMP_LO];
         aux_clock_output_r.cmos_antiphase <= aux_cmos_w;
      end
   end

   // Interrupt enables, reserved bits dropped
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_enable_r <= IRQ_ENABLE_RESET[NUM_EVENTS-1:0];
      end else if (we_ien) begin
         irq_enable_r <= reg_req.wdata[NUM_EVENTS-1:0];
      end
   end

   // Read data selection, unmapped addresses read zero
   always_comb begin
      if (hit_frac) begin
         rdata_nxt = {fractional_clock_output_r.power_on, 2'h0, fractional_clock_output_r.lvpecl,
                      fractional_clock_output_r.amplitude, 2'h0};
      end else if (hit_aux) begin
         rdata_nxt = {aux_clock_output_r.powerdown, 1'h0, aux_clock_output_r.style,
                      aux_clock_output_r.amplitude, 2'h0};
      end else if (hit_ien) begin
         rdata_nxt = {2'h0, irq_enable_r};
      end else if (hit_latched) begin
         rdata_nxt = {2'h0, ~event_seen};
      end else if (hit_moment) begin
         rdata_nxt = {1'h0, status_in.selected_input_status, status_in.event_now};
      end else if (hit_osc) begin
         rdata_nxt = {5'h0, status_in.oscillator_select_now, 2'h0};
      end else begin
         rdata_nxt = int_rd_any;
      end
   end

   // Read port: data lands one cycle after the read strobe and holds
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_r <= ZERO_BYTE;
         reg_rvalid_r <= 1'b0;
      end else begin
         reg_rvalid_r <= reg_req.read;
         if (reg_req.read) begin
            reg_rdata_r <= rdata_nxt;
         end
      end
   end

   // Active-low interrupt from any enabled latched event
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_out_n_r <= 1'b1;
      end else begin
         irq_out_n_r <= ~(|irq_request);
      end
   end

   // Checks
   a_irq_low_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ##1 (irq_out_n_r == !$past(|(event_seen & irq_enable_r))))
      else $error("interrupt output does not follow enabled latched events");
   a_irq_masked_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (irq_enable_r == '0) ##1 (irq_enable_r == '0) |-> irq_out_n_r)
      else $error("interrupt asserted with all enables off");
   a_latched_read_view: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_req.read && hit_latched) |=> (reg_rdata_r[NUM_EVENTS-1:0] == ~$past(event_seen)))
      else $error("latched status readback wrong");
   a_select_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_req.read && hit_moment) |=>
      (reg_rdata_r[BIT_SELECTED] == $past(status_in.selected_input_status)))
      else $error("selected input status readback wrong");
   a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_req.read && (hit_osc || hit_latched || hit_ien)) |=>
      (reg_rdata_r[7:6] == 2'h0) && (!$past(hit_osc) || (reg_rdata_r[1:0] == 2'h0)))
      else $error("reserved status bit read nonzero");
   a_int_pd_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_req.write && hit_int[0]) |=>
      (integer_clock_output_r[0].powerdown == $past(reg_req.wdata[BIT_POWER])) &&
      (integer_clock_output_r[0].amplitude == $past(reg_req.wdata[AMP_HI:AMP_LO])))
      else $error("integer output control not stored");
   a_frac_channel_pd: assert property (@(posedge clk_sys) disable iff (!rst_n)
      fractional_clock_output_r.channel_powerdown == !fractional_clock_output_r.power_on)
      else $error("fractional channel power disagrees with power bit");
   a_aux_cmos_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
      aux_clock_output_r.cmos_antiphase == aux_clock_output_r.style[1])
      else $error("aux antiphase flag disagrees with format");
   a_aux_pd_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      we_aux |=> (aux_clock_output_r.powerdown == $past(reg_req.wdata[BIT_POWER])))
      else $error("aux powerdown not stored");
   c_irq_raised: cover property (@(posedge clk_sys) disable iff (!rst_n)
      irq_out_n_r ##1 !irq_out_n_r);
   c_latched_cleared: cover property (@(posedge clk_sys) disable iff (!rst_n)
      (we_latched && (event_seen != '0)) ##1 (event_seen == '0));
   c_aux_to_lvds: cover property (@(posedge clk_sys) disable iff (!rst_n)
      we_aux && (aux_style_w == AUX_STYLE_LVDS));
   c_frac_powered: cover property (@(posedge clk_sys) disable iff (!rst_n)
      we_frac && reg_req.wdata[BIT_POWER]);
endmodule : clock_output_and_status_regs

// [clkreg_pkg.sv]
// Constants, field layouts and carrier types for the clock output and status register bank
// Notes on behaviour
// - Integer output powerdown bit: set powers down, reset 0
// - Aux output powerdown bit: set powers down, reset 0
// - Fractional power bit low powers down whole channel
// - Single format bit: 0 LVDS, 1 LVPECL
// - Aux format: 00 LVDS, 01 LVPECL, 1x LVCMOS
// - Aux LVCMOS pins driven complementary, 180 degrees apart
// - Enabled latched event pulls interrupt output low
// - Latched bit reads 0 after event; write 1 clears
// - Selection status bit shows chosen input, 0 or 1
package clkreg_pkg;
   // Register port widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   // Number of integer-divider outputs and of latched events
   localparam int NUM_INT_OUT = 10;
   localparam int NUM_EVENTS = 6;
   // Integer output register addresses, bank A, B, C then D
   localparam logic [ADDR_W-1:0] ADDR_INT_OUT [NUM_INT_OUT] = '{
      8'h28, 8'h29, 8'h2a, 8'h30, 8'h31, 8'h32, 8'h38, 8'h39, 8'h40, 8'h41};
   // Remaining register addresses
   localparam logic [ADDR_W-1:0] ADDR_FRAC_OUT = 8'h48;
   localparam logic [ADDR_W-1:0] ADDR_AUX_OUT = 8'h4b;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 8'h4c;
   localparam logic [ADDR_W-1:0] ADDR_LATCHED = 8'h50;
   localparam logic [ADDR_W-1:0] ADDR_MOMENTARY = 8'h51;
   localparam logic [ADDR_W-1:0] ADDR_OSC_SELECT = 8'h53;
   // Field positions inside the output registers
   localparam int BIT_POWER = 7;
   localparam int BIT_STYLE = 4;
   localparam int AUX_STYLE_LO = 4;
   localparam int AUX_STYLE_HI = 5;
   localparam int AMP_LO = 2;
   localparam int AMP_HI = 3;
   // Field positions inside the status registers
   localparam int BIT_SELECTED = 6;
   localparam int BIT_OSC_SELECT = 2;
   // Event bit order in the enable and latched registers
   localparam int EV_INPUT0 = 0;
   localparam int EV_INPUT1 = 1;
   localparam int EV_HOLDOVER = 2;
   localparam int EV_REFERENCE = 3;
   localparam int EV_OSC_PLL = 4;
   localparam int EV_SYNTH = 5;
   // Codes and reset values
   localparam logic [1:0] AMP_500MV = 2'h1;
   localparam logic [1:0] AMP_350MV = 2'h0;
   localparam logic STYLE_LVDS = 1'h0;
   localparam logic [1:0] AUX_STYLE_LVDS = 2'h0;
   localparam logic [1:0] AUX_STYLE_LVPECL = 2'h1;
   localparam logic [1:0] AUX_STYLE_LVCMOS = 2'h2;
   localparam logic PD_POWERED = 1'h0;
   localparam logic FRAC_POWER_OFF = 1'h0;
   localparam logic [DATA_W-1:0] IRQ_ENABLE_RESET = 8'h00;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

   // Register access request from the serial configuration port
   typedef struct packed {
      logic write;
      logic read;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_s;
   // Integer output control
   typedef struct packed {
      logic powerdown;
      logic lvpecl;
      logic [1:0] amplitude;
   } int_out_s;
   // Fractional output control
   typedef struct packed {
      logic power_on;
      logic channel_powerdown;
      logic lvpecl;
      logic [1:0] amplitude;
   } frac_out_s;
   // Auxiliary output control
   typedef struct packed {
      logic powerdown;
      logic [1:0] style;
      logic [1:0] amplitude;
      logic cmos_antiphase;
   } aux_out_s;
   // Momentary status from the detectors and the selection machine
   typedef struct packed {
      logic selected_input_status;
      logic oscillator_select_now;
      logic [NUM_EVENTS-1:0] event_now;
   } status_in_s;
endpackage : clkreg_pkg

// [status_latch_cell.sv]
// One sticky event latch with clear and interrupt request
`timescale 1ns/1ps
module status_latch_cell (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic healthy_now,
   input wire logic clear,
   input wire logic irq_enable,
   output logic event_seen_r,
   output logic irq_request
);
   // Fault is present while the momentary bit reads 0
   wire fault_now = ~healthy_now;
   // Set wins over a clear written in the same cycle
   wire event_seen_nxt = fault_now | (event_seen_r & ~clear);

   // Sticky flag
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         event_seen_r <= 1'b0;
      end else begin
         event_seen_r <= event_seen_nxt;
      end
   end

   // Request toward the interrupt output, gated by its enable
   assign irq_request = event_seen_r & irq_enable;

   a_set_wins_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fault_now && clear) |=> event_seen_r)
      else $error("event lost against a simultaneous clear");
   a_clear_drops_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clear && healthy_now) |=> !event_seen_r)
      else $error("latched flag survived a clear");
endmodule : status_latch_cell

// [clock_output_and_status_regs_test.sv]
// Self-checking testbench for the clock output and status register bank
`timescale 1ns/1ps
module clock_output_and_status_regs_test;
   import clkreg_pkg::*;
   logic clk_sys = 1'b0; // System clock, 50 MHz
   logic resetn = 1'b0; // Active-low reset
   reg_req_s reg_req = '0; // Register access request
   status_in_s status_in = '1; // Detectors start healthy
   logic [DATA_W-1:0] reg_rdata_r; // Read data
   logic reg_rvalid_r; // Read data valid pulse
   int_out_s [NUM_INT_OUT-1:0] integer_clock_output_r; // Integer output controls
   frac_out_s fractional_clock_output_r; // Fractional output control
   aux_out_s aux_clock_output_r; // Auxiliary output control
   logic irq_out_n_r; // Active-low interrupt
   int fail_count = 0; // Mismatches seen
   int compares = 0; // Comparisons made
   logic [1:0] amp; // Code under test in the code loop
   logic [7:0] ev_mask; // One-hot event under test

   // Clock generator
   always #10 clk_sys = ~clk_sys;

   clock_output_and_status_regs u_clock_output_and_status_regs (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .reg_req(reg_req),
      .status_in(status_in),
      .reg_rdata_r(reg_rdata_r),
      .reg_rvalid_r(reg_rvalid_r),
      .integer_clock_output_r(integer_clock_output_r),
      .fractional_clock_output_r(fractional_clock_output_r),
      .aux_clock_output_r(aux_clock_output_r),
      .irq_out_n_r(irq_out_n_r)
   );

   // Compare one byte and report a mismatch
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // One write cycle, returns just after the edge that takes it
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk_sys);
      reg_req <= '{1'b1, 1'b0, addr, data};
      @(posedge clk_sys);
      reg_req.write <= 1'b0;
      #1;
   endtask : wr

   // One read cycle, checks the valid pulse and the data
   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_req <= '{1'b0, 1'b1, addr, 8'h00};
      @(posedge clk_sys);
      reg_req.read <= 1'b0;
      #1;
      chk({7'h0, reg_rvalid_r}, 8'h01, "read valid");
      chk(reg_rdata_r, exp, "read data");
      @(posedge clk_sys);
      #1;
      chk({7'h0, reg_rvalid_r}, 8'h00, "valid not single");
   endtask : rd

   // Verdict and end of run
   task automatic stop_test;
      if (fail_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test

   // Watchdog against a hang
   initial begin
      repeat (4000) @(posedge clk_sys);
      fail_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      stop_test();
   end

   // Main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      // Reset values while reset is held
      for (int i = 0; i < NUM_INT_OUT; i++) begin
         chk({4'h0, integer_clock_output_r[i]}, 8'h01, "int reset");
      end
      chk({3'h0, fractional_clock_output_r}, 8'h09, "frac reset");
      chk({2'h0, aux_clock_output_r}, 8'h11, "aux reset");
      chk({7'h0, irq_out_n_r}, 8'h01, "irq reset");
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      // Every integer output: readback, set all fields, reserved bits dropped
      for (int i = 0; i < NUM_INT_OUT; i++) begin
         rd(ADDR_INT_OUT[i], 8'h04);
         wr(ADDR_INT_OUT[i], 8'hff);
         chk({4'h0, integer_clock_output_r[i]}, 8'h0f, "int set");
         rd(ADDR_INT_OUT[i], 8'h9c);
      end
      rd(ADDR_FRAC_OUT, 8'h04);
      rd(ADDR_AUX_OUT, 8'h20);
      // Every amplitude and aux format code
      for (int a = 0; a < 4; a++) begin
         amp = a[1:0];
         wr(ADDR_INT_OUT[9], {4'h0, amp, 2'h0});
         chk({4'h0, integer_clock_output_r[9]}, {6'h0, amp}, "int amp");
         wr(ADDR_FRAC_OUT, {1'b1, 2'h0, amp[0], amp, 2'h0});
         chk({3'h0, fractional_clock_output_r}, {3'h2, amp[0], amp}, "frac");
         rd(ADDR_FRAC_OUT, {1'b1, 2'h0, amp[0], amp, 2'h0});
         wr(ADDR_AUX_OUT, {amp[0], 1'b0, amp, amp, 2'h0});
         chk({2'h0, aux_clock_output_r}, {2'h0, amp[0], amp, amp, amp[1]}, "aux");
         rd(ADDR_AUX_OUT, {amp[0], 1'b0, amp, amp, 2'h0});
      end
      wr(ADDR_FRAC_OUT, 8'h00);
      chk({3'h0, fractional_clock_output_r}, 8'h08, "frac off");
      // Enables: reserved bits read zero
      rd(ADDR_IRQ_ENABLE, 8'h00);
      wr(ADDR_IRQ_ENABLE, 8'hff);
      rd(ADDR_IRQ_ENABLE, 8'h3f);
      rd(ADDR_LATCHED, 8'h3f);
      // Momentary selection and oscillator status, writes ignored
      @(posedge clk_sys);
      status_in <= '{1'b0, 1'b0, 6'h3f};
      rd(ADDR_MOMENTARY, 8'h3f);
      rd(ADDR_OSC_SELECT, 8'h00);
      @(posedge clk_sys);
      status_in <= '{1'b1, 1'b1, 6'h3f};
      rd(ADDR_MOMENTARY, 8'h7f);
      rd(ADDR_OSC_SELECT, 8'h04);
      wr(ADDR_MOMENTARY, 8'h00);
      rd(ADDR_MOMENTARY, 8'h7f);
      // Each event: one-cycle fault, latch, interrupt two edges later, clear
      for (int i = 0; i < NUM_EVENTS; i++) begin
         ev_mask = 8'h01 << i;
         @(posedge clk_sys);
         status_in.event_now[i] <= 1'b0;
         @(posedge clk_sys);
         status_in.event_now[i] <= 1'b1;
         #1;
         chk({7'h0, irq_out_n_r}, 8'h01, "irq early");
         @(posedge clk_sys);
         #1;
         chk({7'h0, irq_out_n_r}, 8'h00, "irq low");
         rd(ADDR_LATCHED, 8'h3f & ~ev_mask);
         wr(ADDR_LATCHED, ev_mask | 8'hc0);
         @(posedge clk_sys);
         #1;
         chk({7'h0, irq_out_n_r}, 8'h01, "irq cleared");
         rd(ADDR_LATCHED, 8'h3f);
      end
      // Disabled event latches but keeps the interrupt high
      wr(ADDR_IRQ_ENABLE, 8'h3e);
      @(posedge clk_sys);
      status_in.event_now[0] <= 1'b0;
      @(posedge clk_sys);
      status_in.event_now[0] <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      chk({7'h0, irq_out_n_r}, 8'h01, "irq masked");
      rd(ADDR_LATCHED, 8'h3e);
      wr(ADDR_LATCHED, 8'h01);
      rd(ADDR_LATCHED, 8'h3f);
      // Clear written while the fault persists leaves the flag set
      @(posedge clk_sys);
      status_in.event_now[1] <= 1'b0;
      wr(ADDR_LATCHED, 8'h02);
      rd(ADDR_LATCHED, 8'h3d);
      @(posedge clk_sys);
      status_in.event_now[1] <= 1'b1;
      wr(ADDR_LATCHED, 8'h02);
      rd(ADDR_LATCHED, 8'h3f);
      // Unmapped address reads zero and ignores writes
      wr(8'h00, 8'hff);
      rd(8'h00, 8'h00);
      stop_test();
   end
endmodule : clock_output_and_status_regs_test
